// ---- rtl/dua_pkg.sv ----
package dua_pkg;
  // Register byte offsets
  localparam logic [7:0] DUA_OFF_CTRL = 8'h00;
  localparam logic [7:0] DUA_OFF_STAT = 8'h04;
  localparam logic [7:0] DUA_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] DUA_OFF_IRQ_CLR = 8'h0c;
  localparam logic [7:0] DUA_OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] DUA_OFF_SPEED = 8'h14;
  localparam logic [7:0] DUA_OFF_TOL = 8'h18;

  // Control bits
  localparam int DUA_CTRL_INIT = 0;
  localparam int DUA_CTRL_DRIVE = 1;
  localparam int DUA_CTRL_ACC0 = 2;
  localparam int DUA_CTRL_ACC1 = 3;
  localparam int DUA_CTRL_CMDERR = 4;
  localparam int DUA_CTRL_DATERR = 5;
  localparam int DUA_CTRL_RETRYOK = 6;

  // Interrupt bits
  localparam int DUA_IRQ_READY = 0;
  localparam int DUA_IRQ_INITOK = 1;
  localparam int DUA_IRQ_WPROT = 2;
  localparam int DUA_IRQ_ERR = 3;
  localparam int DUA_IRQ_W = 4;

  localparam logic [1:0] DUA_RESP_OKAY = 2'h0;
  localparam logic [1:0] DUA_RESP_SLVERR = 2'h2;

  // Times
  localparam longint DUA_CLK_HZ = 250000000;
  localparam longint DUA_READY_MS = 10000;
  localparam longint DUA_READY_CYC = DUA_READY_MS * (DUA_CLK_HZ / 1000);
  localparam longint DUA_FLASH_MS = 200;
  localparam longint DUA_FLASH_CYC = DUA_FLASH_MS * (DUA_CLK_HZ / 1000);
  localparam logic [15:0] DUA_SPEED_NOM = 16'h0258;
  localparam logic [15:0] DUA_SPEED_TOL = 16'h000c;
  // Test switch pattern up, down, up selects selftest
  localparam logic [2:0] DUA_TEST_SELF = 3'h5;

  typedef enum {DUA_IDLE, DUA_MEASURE, DUA_DONE} dua_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [2:0] test;
  } dua_switch_t;
endpackage : dua_pkg

// ---- rtl/dua_unit.sv ----
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Function
// RL1: Bus address is three up-is-one switches weighted four, two, one; range 0 to 7.
// RL2: Test switch pattern up is normal; up, down, up starts selftest.
// RL3: Two drives answer at one address; drive chosen by command, not address.
// RL4: Activity light lit while its drive is accessed, and briefly at power-up.
// RL5: Ready is withheld until about ten seconds after power-up.
// RL6: Initialization request first measures spindle speed against tolerance.
// RL7: Speed out of tolerance aborts initialization without writing; reports write protect.
// RL8: Selftest light stays lit while command-sequence or data error persists.
// RL9: A successful retry clears the recorded error and its light.
// RL10: Switches are sampled once at reset and held until next power cycle.
module dua_unit
  import dua_pkg::*;
#(
  parameter longint READY_CYC = DUA_READY_CYC,
  parameter longint FLASH_CYC = DUA_FLASH_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire dua_switch_t switches,
  input wire logic speed_valid,
  input wire logic [15:0] speed_rpm,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [2:0] bus_addr,
  output logic selftest_mode,
  output logic ready,
  output logic [1:0] activity_led,
  output logic selftest_led,
  output logic write_enable,
  output logic irq
);
  // Three-stage pin synchroniser; switches are latched once two successive samples agree
  dua_switch_t sw1_q, sw2_q, sw3_q;
  dua_switch_t sw_d, sw_q;
  logic sampled_d, sampled_q;
  logic [39:0] rdy_cnt_d, rdy_cnt_q;
  logic ready_d, ready_q;
  logic flash_d;
  dua_state_t st_d, st_q;
  logic init_req;
  logic wprot_ev, initok_ev, err_ev;
  logic err_d, err_q;
  logic sp1_q, sp2_q, sp3_q;
  // Marks when the synchroniser stages carry pin values rather than reset zeros
  logic [2:0] fill_q;
  logic [15:0] spd1_q, spd2_q, spd3_q;
  logic [15:0] spd_d, spd_q;
  logic [15:0] tol_d, tol_q;
  logic [7:0] ctrl_d, ctrl_q;
  localparam int IRQ_W = DUA_IRQ_W;
  logic [IRQ_W-1:0] ist_d, ist_q, ien_d, ien_q;
  logic aw_d, aw_q, w_d, w_q, bv_d, bv_q, ar_d, ar_q, rv_d, rv_q;
  logic awrdy_q, wrdy_q, ardy_q;
  logic [7:0] awa_d, awa_q;
  logic [31:0] wd_d, wd_q, rd_d, rd_q;
  logic [1:0] br_d, br_q, rr_d, rr_q;
  logic wr_fire;
  logic [IRQ_W-1:0] clr_w;
  logic init_write;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sw1_q <= '0;
      sw2_q <= '0;
      sw3_q <= '0;
      fill_q <= '0;
      sp1_q <= '0;
      sp2_q <= '0;
      sp3_q <= '0;
      spd1_q <= '0;
      spd2_q <= '0;
      spd3_q <= '0;
    end else begin
      sw1_q <= switches;
      sw2_q <= sw1_q;
      sw3_q <= sw2_q;
      fill_q <= {fill_q[1:0], 1'b1};
      sp1_q <= speed_valid;
      sp2_q <= sp1_q;
      sp3_q <= sp2_q;
      spd1_q <= speed_rpm;
      spd2_q <= spd1_q;
      spd3_q <= spd2_q;
    end
  end

  // Power-up: latch switches once, time ready, flash the activity lights
  always_comb begin
    sw_d = sw_q;
    sampled_d = sampled_q;
    if (!sampled_q && fill_q[2] && (sw2_q == sw3_q)) begin
      sw_d = sw3_q; // RL10
      sampled_d = 1'b1;
    end
    rdy_cnt_d = rdy_cnt_q;
    if (!ready_q) begin
      rdy_cnt_d = rdy_cnt_q + 40'h1;
    end
    ready_d = ready_q | (rdy_cnt_q >= 40'(READY_CYC - 1)); // RL5
    flash_d = (rdy_cnt_q < 40'(FLASH_CYC)) && !ready_q; // RL4
  end

  // Speed check before any initialization write
  assign init_req = wr_fire && (awa_q == DUA_OFF_CTRL) && wd_q[DUA_CTRL_INIT];
  logic speed_ok;
  assign speed_ok = (spd_q >= DUA_SPEED_NOM - tol_q) && (spd_q <= DUA_SPEED_NOM + tol_q);
  always_comb begin
    st_d = st_q;
    wprot_ev = 1'b0;
    initok_ev = 1'b0;
    init_write = 1'b0;
    spd_d = spd_q;
    case (st_q)
      DUA_IDLE: begin
        if (init_req && ready_q) begin
          st_d = DUA_MEASURE; // RL6
        end
      end
      DUA_MEASURE: begin
        if (sp3_q && sp2_q) begin
          spd_d = spd3_q;
          st_d = DUA_DONE;
        end
      end
      DUA_DONE: begin
        if (speed_ok) begin
          initok_ev = 1'b1;
          init_write = 1'b1;
        end else begin
          wprot_ev = 1'b1; // RL7
        end
        st_d = DUA_IDLE;
      end
      default: st_d = DUA_IDLE;
    endcase
  end

  // Error light holds until a successful retry
  always_comb begin
    err_d = err_q;
    err_ev = 1'b0;
    if (ctrl_q[DUA_CTRL_CMDERR] || ctrl_q[DUA_CTRL_DATERR]) begin
      err_d = 1'b1; // RL8
      err_ev = !err_q;
    end else if (ctrl_q[DUA_CTRL_RETRYOK]) begin
      err_d = 1'b0; // RL9
    end
  end

  // AXI4-Lite slave: address and data taken in either order
  assign wr_fire = aw_q && w_q && !bv_q;
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    bv_d = bv_q;
    br_d = br_q;
    ar_d = 1'b0;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    ctrl_d = ctrl_q;
    tol_d = tol_q;
    ien_d = ien_q;
    clr_w = '0;
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !w_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
    end
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = DUA_RESP_OKAY;
      case (awa_q)
        DUA_OFF_CTRL: ctrl_d = wd_q[7:0];
        DUA_OFF_IRQ_CLR: clr_w = wd_q[IRQ_W-1:0];
        DUA_OFF_IRQ_EN: ien_d = wd_q[IRQ_W-1:0];
        DUA_OFF_TOL: tol_d = wd_q[15:0];
        default: br_d = DUA_RESP_SLVERR;
      endcase
    end else begin
      ctrl_d[DUA_CTRL_INIT] = 1'b0;
      ctrl_d[DUA_CTRL_RETRYOK] = 1'b0;
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (s_axi_arvalid && !ar_q && !rv_q) begin
      ar_d = 1'b1;
      rv_d = 1'b1;
      rr_d = DUA_RESP_OKAY;
      case (s_axi_araddr[7:0])
        DUA_OFF_CTRL: rd_d = {24'h0, ctrl_q};
        // RL1 RL3: one address for both drives
        DUA_OFF_STAT: rd_d = {24'h0, err_q, ready_q, (sw_q.test == DUA_TEST_SELF), sw_q.addr, 2'h0};
        DUA_OFF_IRQ_STAT: rd_d = {28'h0, ist_q};
        DUA_OFF_IRQ_EN: rd_d = {28'h0, ien_q};
        DUA_OFF_SPEED: rd_d = {16'h0, spd_q};
        DUA_OFF_TOL: rd_d = {16'h0, tol_q};
        default: begin
          rd_d = 32'h0;
          rr_d = DUA_RESP_SLVERR;
        end
      endcase
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    // Set wins over clear
    ist_d = (ist_q & ~clr_w) | {err_ev, wprot_ev, initok_ev, ready_d & !ready_q};
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sw_q <= '0;
      sampled_q <= 1'b0;
      rdy_cnt_q <= '0;
      ready_q <= 1'b0;
      awrdy_q <= 1'b1;
      wrdy_q <= 1'b1;
      ardy_q <= 1'b1;
      st_q <= DUA_IDLE;
      err_q <= 1'b0;
      spd_q <= '0;
      tol_q <= DUA_SPEED_TOL;
      ctrl_q <= '0;
      ist_q <= '0;
      ien_q <= '0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      bv_q <= 1'b0;
      br_q <= '0;
      ar_q <= 1'b0;
      rv_q <= 1'b0;
      rd_q <= '0;
      rr_q <= '0;
      bus_addr <= '0;
      selftest_mode <= 1'b0;
      ready <= 1'b0;
      activity_led <= '0;
      selftest_led <= 1'b0;
      write_enable <= 1'b0;
      irq <= 1'b0;
    end else begin
      sw_q <= sw_d;
      sampled_q <= sampled_d;
      rdy_cnt_q <= rdy_cnt_d;
      ready_q <= ready_d;
      awrdy_q <= !aw_d;
      wrdy_q <= !w_d;
      ardy_q <= !rv_d;
      st_q <= st_d;
      err_q <= err_d;
      spd_q <= spd_d;
      tol_q <= tol_d;
      ctrl_q <= ctrl_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
      aw_q <= aw_d;
      w_q <= w_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      bv_q <= bv_d;
      br_q <= br_d;
      ar_q <= ar_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
      bus_addr <= sw_d.addr; // RL1
      selftest_mode <= sampled_d && (sw_d.test == DUA_TEST_SELF); // RL2
      ready <= ready_d;
      activity_led <= {ctrl_d[DUA_CTRL_ACC1], ctrl_d[DUA_CTRL_ACC0]} | {2{flash_d}}; // RL4
      selftest_led <= err_d; // RL8
      write_enable <= init_write; // RL7
      irq <= |(ist_d & ien_d);
    end
  end

  assign s_axi_awready = awrdy_q;
  assign s_axi_wready = wrdy_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = ardy_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;

  AST_READY_HOLD: assert property (@(posedge clock) disable iff (reset)
    ready |=> ready) else $error("ready dropped"); // RL5
  AST_ADDR_STABLE: assert property (@(posedge clock) disable iff (reset)
    sampled_q |=> $stable(sw_q)) else $error("switch latch changed"); // RL10
  AST_WPROT: assert property (@(posedge clock) disable iff (reset)
    (st_q == DUA_DONE && !speed_ok) |=> !write_enable && ist_q[DUA_IRQ_WPROT])
    else $error("bad speed not refused"); // RL7
  AST_MEASURE: assert property (@(posedge clock) disable iff (reset)
    write_enable |-> $past(st_q, 1) == DUA_DONE) else $error("write without check"); // RL6
  AST_ERR_LED: assert property (@(posedge clock) disable iff (reset)
    (ctrl_q[DUA_CTRL_CMDERR] || ctrl_q[DUA_CTRL_DATERR]) |=> selftest_led)
    else $error("error light off"); // RL8
  AST_RETRY: assert property (@(posedge clock) disable iff (reset)
    (ctrl_q[DUA_CTRL_RETRYOK] && !ctrl_q[DUA_CTRL_CMDERR] && !ctrl_q[DUA_CTRL_DATERR])
    |=> !selftest_led) else $error("retry did not clear"); // RL9
  AST_ADDR_OUT: assert property (@(posedge clock) disable iff (reset)
    sampled_q |-> bus_addr == sw_q.addr) else $error("address mismatch"); // RL1
  AST_TEST: assert property (@(posedge clock) disable iff (reset)
    selftest_mode |-> sw_q.test == DUA_TEST_SELF) else $error("selftest wrong pattern"); // RL2
endmodule : dua_unit

// ---- test/dua_host.sv ----
`timescale 1ns/1ps
// Host side of the register bus; one write and one read at most in flight
module dua_host (
  input wire logic clock,
  output logic [31:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [31:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // Each channel is dropped only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tw;
    @(posedge clock);
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (!ta && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ta && tw));
    while (!bvalid) @(posedge clock);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clock);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : dua_host

// ---- test/dua_unit_test.sv ----
`timescale 1ns/1ps
module dua_unit_test;
  import dua_pkg::*;
  localparam longint RDY = 50;
  logic clock = 1'b0;
  logic reset = 1'b1;
  dua_switch_t switches = '0;
  logic speed_valid = 1'b0;
  logic [15:0] speed_rpm = 16'h0000;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r, activity_led;
  logic [2:0] bus_addr;
  logic selftest_mode, ready, selftest_led, write_enable, irq;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int rel = 0;
  int we_cnt = 0;

  always #2 clock = ~clock;

  // Budget covers nine resets plus the register traffic with wide margin
  always @(posedge clock) begin
    cyc++;
    if (write_enable) we_cnt++;
    if (cyc == 20000) begin
      err_total++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
  end

  dua_unit #(.READY_CYC(RDY), .FLASH_CYC(10)) dut_u (.clock(clock), .reset(reset),
    .switches(switches), .speed_valid(speed_valid), .speed_rpm(speed_rpm),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bus_addr(bus_addr), .selftest_mode(selftest_mode), .ready(ready),
    .activity_led(activity_led), .selftest_led(selftest_led),
    .write_enable(write_enable), .irq(irq));

  dua_host host_u (.clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task stop_test();
    $display("mismatches %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task rst(input dua_switch_t s);
    @(posedge clock);
    reset <= 1'b1;
    switches <= s;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    rel = cyc;
    for (int k = 0; k < 40 && activity_led !== 2'b11; k++) @(posedge clock);
    chk(activity_led, 2'b11, "no power-up flash");
    for (int k = 0; k < 40 && activity_led !== 2'b00; k++) @(posedge clock);
    chk(activity_led, 2'b00, "flash stuck");
    chk(bus_addr, s.addr, "address");
    chk(selftest_mode, s.test == 3'b101, "test mode");
    switches <= ~s;
    repeat (5) @(posedge clock);
    chk(bus_addr, s.addr, "address moved");
    chk(selftest_mode, s.test == 3'b101, "mode moved");
  endtask : rst

  task t_init(input logic [15:0] sp, input logic pass);
    int n;
    speed_rpm <= sp;
    speed_valid <= 1'b1;
    host_u.wr(DUA_OFF_IRQ_CLR, 32'hf, r);
    n = we_cnt;
    host_u.wr(DUA_OFF_CTRL, 32'h1, r);
    repeat (30) @(posedge clock);
    chk(we_cnt - n, pass, "write enable count");
    host_u.rd(DUA_OFF_IRQ_STAT, d, r);
    chk(d[2:1], {!pass, pass}, "init result");
    host_u.rd(DUA_OFF_SPEED, d, r);
    chk(d, {16'h0, sp}, "measured speed");
  endtask : t_init

  task t_err(input int b);
    host_u.wr(DUA_OFF_CTRL, 32'h1 << b, r);
    repeat (3) @(posedge clock);
    chk(selftest_led, 1'b1, "error light");
    host_u.wr(DUA_OFF_CTRL, (32'h1 << b) | 32'h40, r);
    repeat (3) @(posedge clock);
    chk(selftest_led, 1'b1, "cleared while error stands");
    host_u.wr(DUA_OFF_CTRL, 32'h40, r);
    repeat (3) @(posedge clock);
    chk(selftest_led, 1'b0, "retry kept light");
  endtask : t_err

  initial begin
    for (int i = 0; i < 8; i++) rst(dua_switch_t'({3'(i), 3'(7 - i)}));
    rst(dua_switch_t'({3'h6, 3'h7}));
    chk(ready, 1'b0, "ready early");
    for (int k = 0; k < 200 && ready !== 1'b1; k++) @(posedge clock);
    chk((cyc - rel) inside {[RDY - 4 : RDY + 4]}, 1'b1, "ready time");
    host_u.wr(DUA_OFF_CTRL, 32'h6, r);
    repeat (3) @(posedge clock);
    chk(activity_led, 2'b01, "drive 0 light");
    host_u.wr(DUA_OFF_CTRL, 32'ha, r);
    repeat (3) @(posedge clock);
    chk(activity_led, 2'b10, "drive 1 light");
    host_u.rd(DUA_OFF_STAT, d, r);
    chk({d[6], d[4:2]}, 4'he, "status address");
    host_u.wr(DUA_OFF_CTRL, 32'h0, r);
    t_init(DUA_SPEED_NOM, 1'b1);
    t_init(DUA_SPEED_NOM + DUA_SPEED_TOL - 16'h1, 1'b1);
    t_init(DUA_SPEED_NOM - DUA_SPEED_TOL - 16'h1, 1'b0);
    t_init(DUA_SPEED_NOM + DUA_SPEED_TOL + 16'h1, 1'b0);
    t_err(DUA_CTRL_CMDERR);
    t_err(DUA_CTRL_DATERR);
    host_u.wr(DUA_OFF_IRQ_EN, 32'h0, r);
    chk(irq, 1'b0, "masked irq");
    host_u.wr(DUA_OFF_IRQ_EN, 32'h4, r);
    repeat (2) @(posedge clock);
    chk(irq, 1'b1, "irq missing");
    host_u.wr(DUA_OFF_IRQ_CLR, 32'h4, r);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0, "irq not cleared");
    host_u.rd(DUA_OFF_TOL, d, r);
    chk(d, 32'hc, "tolerance default");
    host_u.wr(8'h40, 32'h1, r);
    chk(r, DUA_RESP_SLVERR, "unmapped write");
    host_u.rd(8'h40, d, r);
    chk(d, 32'h0, "unmapped read data");
    chk(r, DUA_RESP_SLVERR, "unmapped read");
    stop_test();
  end
endmodule : dua_unit_test
